// ---- include/sfsfe_regs.vh ----
`ifndef SFSFE_REGS_VH
`define SFSFE_REGS_VH
// Link framing.
`define SFSFE_OPC_BITS        4'h8
`define SFSFE_ADDR_BITS       6'h18
`define SFSFE_BITCNT_W        6
// Array geometry.
`define SFSFE_PAGE_SIZE_STD   16'h0108
`define SFSFE_PAGE_SIZE_BIN   16'h0100
`define SFSFE_PAGE_COUNT      17'h0_8000
`define SFSFE_SECT_COUNT      8'h20
`define SFSFE_SECT_SHIFT      4'hA
`define SFSFE_SEC_AREA_BYTES  8'h80
`define SFSFE_SEC_FACTORY     8'h40
// Internal operation timing.
`define SFSFE_T_BUSY_US       16'h0064
`define SFSFE_CLK_MHZ         16'h0064
// Opcode classes handled at the front end.
`define SFSFE_OP_PAGE_PROG    8'h82
`define SFSFE_OP_BUF1_PROG    8'h83
`define SFSFE_OP_BUF2_PROG    8'h86
`define SFSFE_OP_PAGE_ERASE   8'h81
`define SFSFE_OP_BLK_ERASE    8'h50
`define SFSFE_OP_SECT_ERASE   8'h7C
`define SFSFE_OP_BUF1_WRITE   8'h84
`define SFSFE_OP_BUF2_WRITE   8'h87
`define SFSFE_OP_READ_STAT    8'hD7
`define SFSFE_OP_PROT_GROUP   8'h3D
`endif

// ---- design/sfsfe_front_end.v ----
`timescale 1ns/10ps
`include "sfsfe_regs.vh"
module sfsfe_front_end #(
   parameter         FACTORY_BIN_PAGE = 1'b0,
   parameter [15:0]  BUSY_CYCLES      = `SFSFE_T_BUSY_US * `SFSFE_CLK_MHZ
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        cs_n,
   input  wire        sck,
   input  wire        si,
   input  wire        wp_n,
   input  wire [31:0] sect_prot_wr,
   input  wire        sect_prot_wr_en,
   input  wire        sw_prot_en,
   output reg         so_o,
   output reg         so_oe,
   output reg         busy,
   output reg         standby,
   output reg  [7:0]  opcode_out,
   output reg  [23:0] addr_out,
   output reg         cmd_valid,
   output reg         cmd_refused,
   output reg         buf_sel,
   output reg  [31:0] sect_prot_rd
);

   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_OPC  = 4'b0010;
   localparam [3:0] ST_ADR  = 4'b0100;
   localparam [3:0] ST_DAT  = 4'b1000;

   // Pin synchronisers: three stages, a change counts when stages two and three agree.
   reg [2:0] cs_s_r;
   reg [2:0] sck_s_r;
   reg [2:0] si_s_r;
   reg [2:0] wp_s_r;
   reg       cs_f_r;
   reg       sck_f_r;
   reg       si_f_r;
   reg       wp_f_r;
   reg       sck_d_r;

   reg [3:0]  st_r;
   reg [5:0]  bitcnt_r;
   reg [7:0]  opc_r;
   reg [23:0] adr_r;
   reg [7:0]  stat_sh_r;
   reg [15:0] busy_cnt_r;
   reg        page_bin_r;
   reg        strap_done_r;
   reg        refuse_r;
   reg        stat_go_r;

   wire sck_rise = sck_f_r & ~sck_d_r;
   wire sck_fall = ~sck_f_r & sck_d_r;
   wire selected = ~cs_f_r;

   // Program and erase opcodes; these are the ones write protection can stop.
   function is_modify;
      input [7:0] op;
      begin
         case (op)
            `SFSFE_OP_PAGE_PROG:  is_modify = 1'b1;
            `SFSFE_OP_BUF1_PROG:  is_modify = 1'b1;
            `SFSFE_OP_BUF2_PROG:  is_modify = 1'b1;
            `SFSFE_OP_PAGE_ERASE: is_modify = 1'b1;
            `SFSFE_OP_BLK_ERASE:  is_modify = 1'b1;
            `SFSFE_OP_SECT_ERASE: is_modify = 1'b1;
            default:              is_modify = 1'b0;
         endcase
      end
   endfunction

   function sect_blocked;
      input [23:0] a;
      input [31:0] prot;
      input        hw;
      input        sw;
      reg   [4:0]  idx;
      begin
         // The sector is the top five address bits, 32 sectors in all.
         idx = a[23:19];
         // Either protection source alone is enough.
         sect_blocked = prot[idx] & (hw | sw);
      end
   endfunction

   // Opcodes that route through the second SRAM buffer.
   function uses_buf2;
      input [7:0] op;
      begin
         case (op)
            `SFSFE_OP_BUF2_PROG:  uses_buf2 = 1'b1;
            `SFSFE_OP_BUF2_WRITE: uses_buf2 = 1'b1;
            default:              uses_buf2 = 1'b0;
         endcase
      end
   endfunction

   // Status byte: ready, a zero, four ones, protect pin state, page size flag.
   function [7:0] status_byte;
      input bsy;
      input wp_low;
      input bin;
      begin
         status_byte = {~bsy, 1'b0, 4'hF, wp_low, bin};
      end
   endfunction

   // A synchronised pin only takes a new level once stages two and three agree.
   function settle;
      input [2:0] s;
      input       cur;
      begin
         settle = (s[1] == s[2]) ? s[2] : cur;
      end
   endfunction

   // A frame end that launches an internal cycle. Standby has to drop in the
   // same cycle as busy rises, not one cycle later.
   wire       busy_start = ~selected & (st_r == ST_DAT) & ~refuse_r & is_modify(opc_r) & ~busy;
   // Status as it stands at the first output fall of a status read.
   wire [7:0] stat_now   = status_byte(busy, ~wp_f_r, page_bin_r);

   // Each chain resets to its pin's idle level, so no false edge follows reset.
   // In mode 3 the clock idles high and shows one rise while deselected, which
   // the sequencer ignores.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cs_s_r <= 3'h7;
         cs_f_r <= 1'b1;
      end else begin
         cs_s_r <= {cs_s_r[1:0], cs_n};
         cs_f_r <= settle(cs_s_r, cs_f_r);
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_s_r <= 3'h0;
         sck_f_r <= 1'b0;
         sck_d_r <= 1'b0;
      end else begin
         sck_s_r <= {sck_s_r[1:0], sck};
         sck_f_r <= settle(sck_s_r, sck_f_r);
         sck_d_r <= sck_f_r;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         si_s_r <= 3'h0;
         si_f_r <= 1'b0;
      end else begin
         si_s_r <= {si_s_r[1:0], si};
         si_f_r <= settle(si_s_r, si_f_r);
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_s_r <= 3'h7;
         wp_f_r <= 1'b1;
      end else begin
         wp_s_r <= {wp_s_r[1:0], wp_n};
         wp_f_r <= settle(wp_s_r, wp_f_r);
      end
   end

   // Page size strap is caught after reset release, default 264 bytes.
   // It is taken once, so pages cannot change size in the middle of an operation.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_done_r <= 1'b0;
         page_bin_r   <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         page_bin_r   <= FACTORY_BIN_PAGE;
      end
   end

   // Front-end sequencer. Reset abandons any operation at once.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r         <= ST_IDLE;
         bitcnt_r     <= 6'h00;
         opc_r        <= 8'h00;
         adr_r        <= 24'h00_0000;
         opcode_out   <= 8'h00;
         addr_out     <= 24'h00_0000;
         cmd_valid    <= 1'b0;
         cmd_refused  <= 1'b0;
         refuse_r     <= 1'b0;
         buf_sel      <= 1'b0;
         busy         <= 1'b0;
         busy_cnt_r   <= 16'h0000;
         sect_prot_rd <= 32'h0000_0000;
      end else begin
         cmd_valid   <= 1'b0;
         cmd_refused <= 1'b0;
         // Program and erase run on an internal counter, no host clocking.
         // There is one counter only: a command that ends while a cycle runs is
         // passed on but does not restart the timer.
         if (busy) begin
            if (busy_cnt_r == 16'h0001)
               busy <= 1'b0;
            busy_cnt_r <= busy_cnt_r - 16'h0001;
         end
         // Protection register is frozen whenever write protect is low.
         // The pin is seen after synchronisation, so a load just after it falls may land.
         if (sect_prot_wr_en && wp_f_r)
            sect_prot_rd <= sect_prot_wr;
         if (!selected) begin
            // Rise of select ends the frame; partial bits are thrown away.
            // Only a frame with the full opcode and all address bits counts.
            if (st_r == ST_DAT) begin
               if (refuse_r) begin
                  // A refused command only pulses cmd_refused, with no cycle started.
                  cmd_refused <= 1'b1;
               end else if (is_modify(opc_r)) begin
                  if (!busy) begin
                     busy       <= 1'b1;
                     busy_cnt_r <= BUSY_CYCLES;
                  end
                  cmd_valid  <= 1'b1;
                  opcode_out <= opc_r;
                  addr_out   <= adr_r;
               end else begin
                  cmd_valid  <= 1'b1;
                  opcode_out <= opc_r;
                  addr_out   <= adr_r;
               end
            end
            st_r     <= ST_IDLE;
            bitcnt_r <= 6'h00;
            refuse_r <= 1'b0;
         end else begin
            case (st_r)
               ST_IDLE: begin
                  // Only a fresh falling select edge opens a frame.
                  st_r     <= ST_OPC;
                  bitcnt_r <= 6'h00;
               end
               ST_OPC: begin
                  if (sck_rise) begin
                     opc_r    <= {opc_r[6:0], si_f_r};
                     bitcnt_r <= bitcnt_r + 6'h01;
                     if (bitcnt_r == {2'b00, `SFSFE_OPC_BITS} - 6'h01) begin
                        st_r     <= ST_ADR;
                        bitcnt_r <= 6'h00;
                     end
                  end
               end
               ST_ADR: begin
                  if (sck_rise) begin
                     adr_r    <= {adr_r[22:0], si_f_r};
                     bitcnt_r <= bitcnt_r + 6'h01;
                     if (bitcnt_r == `SFSFE_ADDR_BITS - 6'h01) begin
                        st_r <= ST_DAT;
                        // Buffer 2 opcodes use the second SRAM buffer.
                        buf_sel <= uses_buf2(opc_r);
                        if (is_modify(opc_r) &&
                            sect_blocked({adr_r[22:0], si_f_r}, sect_prot_rd,
                                         ~wp_f_r, sw_prot_en))
                           refuse_r <= 1'b1;
                     end
                  end
               end
               ST_DAT: begin
                  // Data bytes are handled by later stages; here they are only framed.
                  bitcnt_r <= 6'h00;
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Output path: status byte shifted out MSB first on SCK falling edges.
   // The first bit leaves on the fall right after the last opcode bit, so the
   // host finds it at the very next rise.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         so_o      <= 1'b0;
         so_oe     <= 1'b0;
         stat_sh_r <= 8'h00;
         stat_go_r <= 1'b0;
         standby   <= 1'b1;
      end else begin
         // Deselect means standby, delayed while an internal cycle runs.
         standby <= ~selected & ~busy & ~busy_start;
         if (!selected) begin
            so_oe     <= 1'b0;
            so_o      <= 1'b0;
            stat_go_r <= 1'b0;
         end else if (sck_fall && st_r != ST_OPC && st_r != ST_IDLE &&
                      opc_r == `SFSFE_OP_READ_STAT) begin
            // Host samples on the next rising edge, so modes 0 and 3 both work.
            so_oe <= 1'b1;
            if (!stat_go_r) begin
               so_o      <= stat_now[7];
               stat_sh_r <= {stat_now[6:0], stat_now[7]};
               stat_go_r <= 1'b1;
            end else begin
               so_o      <= stat_sh_r[7];
               stat_sh_r <= {stat_sh_r[6:0], stat_sh_r[7]};
            end
         end
      end
   end

   // Array geometry is fixed: 32768 pages, each 256 or 264 bytes as strapped,
   // and a 128-byte security area whose first 64 bytes come from the factory.
   // These figures bound the addresses that later stages decode.
   localparam [16:0] PAGE_COUNT     = `SFSFE_PAGE_COUNT;
   localparam [7:0]  SEC_AREA_BYTES = `SFSFE_SEC_AREA_BYTES;
   localparam [7:0]  SEC_USER_BYTES = `SFSFE_SEC_AREA_BYTES - `SFSFE_SEC_FACTORY;

endmodule // sfsfe_front_end

// ---- bench/sfsfe_asserts.sv ----
`timescale 1ns/10ps
module sfsfe_chk #(
   parameter [15:0] BUSY_CYCLES = 16'h2710
) (
   input wire        clk,
   input wire        rstn,
   input wire        cs_n,
   input wire        sck,
   input wire        wp_n,
   input wire        sect_prot_wr_en,
   input wire        so_o,
   input wire        so_oe,
   input wire        busy,
   input wire        standby,
   input wire        cmd_valid,
   input wire        cmd_refused,
   input wire [31:0] sect_prot_rd
);
   localparam int BLO = BUSY_CYCLES - 3;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_SO_HIZ: assert property (cs_n [*6] |-> !so_oe) else $error("so driven");
   AST_STBY_BUSY: assert property (busy |-> !standby) else $error("standby busy");
   AST_STBY_SEL: assert property (!cs_n [*8] |-> !standby) else $error("standby sel");
   AST_DESEL_QUIET: assert property (cs_n [*8] |-> !cmd_valid && !cmd_refused)
      else $error("pulse while deselected");
   AST_ONE_PULSE: assert property (cmd_valid || cmd_refused |=> !cmd_valid && !cmd_refused)
      else $error("pulse too long");
   AST_REF_IDLE: assert property (cmd_refused && !busy |=> !busy [*3]) else $error("refused ran");
   AST_WP_HOLD: assert property (!wp_n && !$past(wp_n) && sect_prot_wr_en |=>
      $stable(sect_prot_rd)) else $error("protection changed");
   AST_BUSY_LEN: assert property ($rose(busy) |-> ##BLO busy ##[1:4] !busy)
      else $error("busy length");
   AST_SO_FALL: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
      else $error("so moved on rise");
   cover property (cmd_valid);
   cover property (cmd_refused);
   cover property ($rose(busy));
endmodule // sfsfe_chk

// ---- bench/sfsfe_host.sv ----
`timescale 1ns/10ps
module sfsfe_host (
   input  wire clk,
   input  wire so,
   output reg  cs_n,
   output reg  sck,
   output reg  si
);
   reg mode3 = 1'b0;
   initial cs_n = 1'b1;
   initial sck = 1'b0;
   initial si = 1'b0;
   // Send nb bits of w MSB first, then clock nr bits in from so.
   task xfer(input [31:0] w, input integer nb, input integer nr, output reg [7:0] rd);
      integer i;
      begin
         @(negedge clk) cs_n = 1'b0;
         si = w[31];
         if (mode3) begin
            repeat (8) @(negedge clk);
            sck = 1'b0;
         end
         for (i = 0; i < nb + nr; i = i + 1) begin
            repeat (8) @(negedge clk);
            sck = 1'b1;
            if (i >= nb) rd = {rd[6:0], so};
            repeat (8) @(negedge clk);
            sck = 1'b0;
            w = w << 1;
            si = w[31];
         end
         sck = mode3;
         repeat (8) @(negedge clk);
         cs_n = 1'b1;
         si = ~si;
         repeat (8) @(negedge clk);
      end
   endtask
endmodule // sfsfe_host

// ---- bench/sfsfe_tb.sv ----
`timescale 1ns/10ps
`include "sfsfe_regs.vh"
module testbench;
   localparam [47:0] MODS = {`SFSFE_OP_PAGE_PROG, `SFSFE_OP_BUF1_PROG, `SFSFE_OP_BUF2_PROG,
                             `SFSFE_OP_PAGE_ERASE, `SFSFE_OP_BLK_ERASE, `SFSFE_OP_SECT_ERASE};
   reg         clk = 0, rstn = 0, wp_n = 1, spw_en = 0, swp = 0, sv = 0, sr = 0;
   reg  [31:0] spw = 0, pexp;
   reg  [7:0]  got_op, rd;
   reg  [23:0] got_a;
   integer     fail_count = 0, n_checks = 0, i, k;
   wire        cs_n, sck, si, so_o, so_oe, busy, standby, cmd_valid, cmd_refused, buf_sel;
   wire [7:0]  opc;
   wire [23:0] adr;
   wire [31:0] spr;
   wire        so_pin = so_oe ? so_o : 1'bz;
   sfsfe_front_end #(.BUSY_CYCLES(16'h0014)) dut (.clk(clk), .rstn(rstn), .cs_n(cs_n),
      .sck(sck), .si(si), .wp_n(wp_n), .sect_prot_wr(spw), .sect_prot_wr_en(spw_en),
      .sw_prot_en(swp), .so_o(so_o), .so_oe(so_oe), .busy(busy), .standby(standby),
      .opcode_out(opc), .addr_out(adr), .cmd_valid(cmd_valid), .cmd_refused(cmd_refused),
      .buf_sel(buf_sel), .sect_prot_rd(spr));
   sfsfe_host host (.clk(clk), .so(so_pin), .cs_n(cs_n), .sck(sck), .si(si));
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (cmd_valid) begin
         sv <= 1'b1;
         got_op <= opc;
         got_a <= adr;
      end
      if (cmd_refused) sr <= 1'b1;
   end
   function is_mod(input [7:0] op);
      integer j;
      begin
         is_mod = 0;
         for (j = 0; j < 6; j = j + 1) if (MODS[8*j +: 8] == op) is_mod = 1;
      end
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("unexpected %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task prot(input [31:0] v);
      begin
         @(negedge clk) spw = v;
         spw_en = 1;
         @(negedge clk) spw_en = 0;
         @(negedge clk);
      end
   endtask
   task cmd(input [7:0] op, input [23:0] ad);
      reg r, b;
      begin
         r = is_mod(op) && pexp[ad[23:19]] && (!wp_n || swp);
         b = !r && is_mod(op);
         sv = 0;
         sr = 0;
         host.xfer({op, ad}, 32, 0, rd);
         repeat (10) @(negedge clk);
         chk("refused", r, sr);
         chk("accepted", !r, sv);
         if (!r) chk("command", {op, ad}, {got_op, got_a});
         chk("busy", b, busy);
         chk("standby", !b, standby);
         for (k = 0; k < 60 && busy !== 1'b0; k = k + 1) @(negedge clk);
         @(negedge clk);
         chk("standby", 1, standby);
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   initial begin
      #1_000_000;
      fail_count = fail_count + 1;
      final_report;
   end
   initial begin
      k = $urandom(6);
      repeat (8) @(negedge clk);
      rstn = 1;
      repeat (2) @(negedge clk);
      chk("standby", 1, standby);
      pexp = $urandom | 32'h0000_0001;
      prot(pexp);
      chk("protection", pexp, spr);
      wp_n = 0;
      repeat (6) @(negedge clk);
      prot(~pexp);
      chk("protection", pexp, spr);
      $display("protection load test done");
      cmd(`SFSFE_OP_PAGE_PROG, 24'h00_0000);
      cmd(`SFSFE_OP_PROT_GROUP, 24'h00_0000);
      for (i = 0; i < 12; i = i + 1) begin
         wp_n = $urandom;
         swp = $urandom;
         cmd(MODS[8*($urandom % 6) +: 8], $urandom);
      end
      $display("protected command test done");
      wp_n = 1;
      swp = 0;
      cmd(`SFSFE_OP_BUF2_WRITE, $urandom);
      chk("buffer", 1, buf_sel);
      cmd(`SFSFE_OP_BUF1_WRITE, $urandom);
      chk("buffer", 0, buf_sel);
      $display("buffer test done");
      sv = 0;
      sr = 0;
      host.xfer(32'hFFFF_FFFF, 13, 0, rd);
      for (i = 0; i < 16; i = i + 1) begin
         @(negedge clk) host.sck = ~host.sck;
         host.si = $urandom;
      end
      repeat (10) @(negedge clk);
      chk("no pulse", 0, {sv, sr});
      cmd(`SFSFE_OP_BLK_ERASE, $urandom);
      $display("partial frame test done");
      for (i = 0; i < 2; i = i + 1) begin
         host.mode3 = i;
         host.sck = i;
         repeat (4) @(negedge clk);
         host.xfer({`SFSFE_OP_READ_STAT, 24'h00_0000}, 8, 8, rd);
         chk("status", 8'hBC, rd & 8'hFD);
      end
      host.mode3 = 0;
      host.sck = 0;
      $display("status test done");
      host.xfer({`SFSFE_OP_PAGE_ERASE, 24'h00_0000}, 32, 0, rd);
      repeat (4) @(negedge clk);
      rstn = 0;
      @(negedge clk);
      chk("reset busy", 0, busy);
      chk("reset standby", 1, standby);
      rstn = 1;
      $display("reset test done");
      final_report;
   end
endmodule // testbench
bind sfsfe_front_end sfsfe_chk #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (.clk(clk), .rstn(rstn),
   .cs_n(cs_n), .sck(sck), .wp_n(wp_n), .sect_prot_wr_en(sect_prot_wr_en), .so_o(so_o),
   .so_oe(so_oe), .busy(busy), .standby(standby), .cmd_valid(cmd_valid),
   .cmd_refused(cmd_refused), .sect_prot_rd(sect_prot_rd));
